// *** rtl/nvm_seq_pkg.sv ***
package nvm_seq_pkg;

  localparam logic [15:0] CTRL_ADDR = 16'h0260;
  localparam logic [15:0] ADDR_LO_ADDR = 16'h0762;
  localparam logic [15:0] ADDR_HI_ADDR = 16'h0764;
  localparam logic [15:0] KEY_ADDR = 16'h0766;

  localparam int GO_BIT = 15;
  localparam int PERMIT_BIT = 14;
  localparam int ABORT_BIT = 13;
  localparam int OP_ERASE_BIT = 6;
  localparam int OP_EEPROM_BIT = 2;
  localparam int OP_MULTI_BIT = 0;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [6:0] OP_RESET = 7'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  localparam logic [23:0] EE_BASE = 24'h7ffc00;
  localparam logic [15:0] EE_ERASED = 16'hffff;
  localparam int EE_WORDS = 512;
  localparam int EE_BLOCK = 16;
  localparam int ROW_WORDS = 32;

  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 2000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT_FIRST = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic wr_low;
    logic wr_high;
    logic rd;
    logic [23:0] addr;
    logic [15:0] wdata;
  } tbl_req_t;

endpackage : nvm_seq_pkg

// *** rtl/unlock_guard.sv ***
`timescale 1ns/1ps
module unlock_guard (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  // register writes from the core
  input wire nvm_seq_pkg::sfr_req_t sfr,
  // unlock state
  output logic armed
);

  nvm_seq_pkg::key_state_t state_r;
  nvm_seq_pkg::key_state_t state_nxt;
  logic key_wr;

  assign key_wr = sfr.wr && sfr.addr == nvm_seq_pkg::KEY_ADDR;
  assign armed = state_r == nvm_seq_pkg::KEY_ARMED;

  always_comb begin
    state_nxt = state_r;
    if (clear) begin
      state_nxt = nvm_seq_pkg::KEY_IDLE;
    end else if (sfr.wr) begin
      // any write that breaks the pair or follows the arming ends it
      unique case (state_r)
        nvm_seq_pkg::KEY_IDLE,
        nvm_seq_pkg::KEY_ARMED: begin
          if (key_wr && sfr.wdata[7:0] == nvm_seq_pkg::KEY_FIRST) begin
            state_nxt = nvm_seq_pkg::KEY_GOT_FIRST;
          end else begin
            state_nxt = nvm_seq_pkg::KEY_IDLE;
          end
        end
        nvm_seq_pkg::KEY_GOT_FIRST: begin
          if (key_wr && sfr.wdata[7:0] == nvm_seq_pkg::KEY_SECOND) begin
            state_nxt = nvm_seq_pkg::KEY_ARMED;
          end else if (key_wr && sfr.wdata[7:0] == nvm_seq_pkg::KEY_FIRST) begin
            state_nxt = nvm_seq_pkg::KEY_GOT_FIRST;
          end else begin
            state_nxt = nvm_seq_pkg::KEY_IDLE;
          end
        end
        default: state_nxt = nvm_seq_pkg::KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= nvm_seq_pkg::KEY_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  property p_arm_needs_pair;
    @(posedge clk) disable iff (!reset_n)
    $rose(armed) |-> $past(key_wr) && $past(sfr.wdata[7:0]) == nvm_seq_pkg::KEY_SECOND
      && $past(state_r) == nvm_seq_pkg::KEY_GOT_FIRST;
  endproperty
  a_arm_needs_pair: assert property (p_arm_needs_pair) else $error("armed without key pair");

  property p_other_write_cancels;
    @(posedge clk) disable iff (!reset_n)
    armed && sfr.wr |=> !armed;
  endproperty
  a_other_write_cancels: assert property (p_other_write_cancels) else $error("unlock outlived a write");

endmodule : unlock_guard

// *** rtl/nvm_program_erase_sequencer.sv ***
`timescale 1ns/1ps
module nvm_program_erase_sequencer #(
  parameter int PROG_CYCLES = nvm_seq_pkg::PROG_CYCLES,
  parameter int EE_WORDS = nvm_seq_pkg::EE_WORDS,
  parameter int EE_BLOCK = nvm_seq_pkg::EE_BLOCK,
  parameter int ROW_WORDS = nvm_seq_pkg::ROW_WORDS
) (
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic external_reset_pin,
  input wire logic watchdog_reset,
  // special register port
  input wire nvm_seq_pkg::sfr_req_t sfr,
  output logic [15:0] sfr_rdata,
  // table instruction port
  input wire nvm_seq_pkg::tbl_req_t tbl,
  output logic [15:0] tbl_rdata,
  // interrupt flag
  input wire logic done_flag_clear,
  output logic nonvolatile_done_flag,
  // program flash array side
  output logic cpu_stall,
  output logic flash_erase_cmd,
  output logic flash_program_cmd,
  output logic [16:0] flash_row,
  input wire logic [4:0] latch_sel,
  output logic [23:0] latch_word
);

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int EW = $clog2(EE_WORDS);
  localparam int BW = $clog2(EE_BLOCK);

  generate
    if (PROG_CYCLES < 2 || EE_WORDS > 512 || (1 << EW) != EE_WORDS || EE_BLOCK != 16 || ROW_WORDS != 32) begin : g_bad
      $error("nvm_program_erase_sequencer: unsupported parameters");
    end
  endgenerate

  logic armed;
  logic warm;
  logic ctrl_wr;
  logic start;
  logic op_done;
  logic tbl_ee;
  logic tbl_flash;
  logic act_ee;
  logic act_erase;
  logic act_multi;
  logic [EW-1:0] tbl_idx;
  logic [EW-1:0] tgt_idx;

  logic go_r, go_nxt;
  logic permit_r, permit_nxt;
  logic abort_r, abort_nxt;
  logic done_r, done_nxt;
  logic [6:0] op_r, op_nxt;
  logic [6:0] act_op_r, act_op_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [15:0] addr_lo_r, addr_lo_nxt;
  logic [6:0] addr_hi_r, addr_hi_nxt;
  logic [22:0] tgt_r, tgt_nxt;
  logic [15:0] sfr_rdata_r, sfr_rdata_nxt;

  logic [15:0] ee_mem [EE_WORDS];
  logic [15:0] ee_latch [EE_BLOCK];
  logic [23:0] row_latch [ROW_WORDS];
  logic [15:0] tbl_rdata_r;
  logic [23:0] latch_word_r;

  // pin and watchdog resets arrive already timed by the reset controller
  assign warm = external_reset_pin || watchdog_reset;

  unlock_guard u_guard (
    .clk(clk),
    .reset_n(reset_n),
    .clear(warm),
    .sfr(sfr),
    .armed(armed)
  );

  assign ctrl_wr = sfr.wr && sfr.addr == nvm_seq_pkg::CTRL_ADDR;
  // permit_r is the value from before this write, so one write cannot both enable and start
  assign start = ctrl_wr && sfr.wdata[nvm_seq_pkg::GO_BIT] && armed && permit_r && !go_r;
  assign op_done = go_r && cnt_r == CW'(1);
  assign tbl_ee = tbl.addr[23:10] == nvm_seq_pkg::EE_BASE[23:10];
  assign tbl_flash = !tbl_ee;
  assign tbl_idx = tbl.addr[EW:1];
  assign tgt_idx = tgt_r[EW:1];
  assign act_ee = act_op_r[nvm_seq_pkg::OP_EEPROM_BIT];
  assign act_erase = act_op_r[nvm_seq_pkg::OP_ERASE_BIT];
  assign act_multi = act_op_r[nvm_seq_pkg::OP_MULTI_BIT];

  always_comb begin
    go_nxt = go_r;
    permit_nxt = permit_r;
    abort_nxt = abort_r;
    done_nxt = done_r;
    op_nxt = op_r;
    act_op_nxt = act_op_r;
    cnt_nxt = cnt_r;
    addr_lo_nxt = addr_lo_r;
    addr_hi_nxt = addr_hi_r;
    tgt_nxt = tgt_r;
    sfr_rdata_nxt = sfr_rdata_r;
    if (ctrl_wr) begin
      permit_nxt = sfr.wdata[nvm_seq_pkg::PERMIT_BIT];
      abort_nxt = sfr.wdata[nvm_seq_pkg::ABORT_BIT];
      if (!go_r) begin
        op_nxt = sfr.wdata[6:0];
      end
    end
    if (sfr.wr && sfr.addr == nvm_seq_pkg::ADDR_LO_ADDR) begin
      addr_lo_nxt = sfr.wdata;
    end
    if (sfr.wr && sfr.addr == nvm_seq_pkg::ADDR_HI_ADDR) begin
      addr_hi_nxt = sfr.wdata[6:0];
    end
    if (tbl.wr_low || tbl.wr_high || tbl.rd) begin
      addr_lo_nxt = tbl.addr[15:0];
      addr_hi_nxt = tbl.addr[22:16];
    end
    if (start) begin
      go_nxt = 1'b1;
      cnt_nxt = CW'(PROG_CYCLES);
      act_op_nxt = sfr.wdata[6:0];
      tgt_nxt = {addr_hi_r, addr_lo_r};
    end else if (go_r) begin
      cnt_nxt = cnt_r - CW'(1);
      if (op_done) begin
        go_nxt = 1'b0;
      end
    end
    // set wins over the software clear
    if (done_flag_clear) begin
      done_nxt = 1'b0;
    end
    if (op_done) begin
      done_nxt = 1'b1;
    end
    if (sfr.rd) begin
      unique case (sfr.addr)
        nvm_seq_pkg::CTRL_ADDR: sfr_rdata_nxt = {go_r, permit_r, abort_r, 6'h00, op_r};
        nvm_seq_pkg::ADDR_LO_ADDR: sfr_rdata_nxt = addr_lo_r;
        nvm_seq_pkg::ADDR_HI_ADDR: sfr_rdata_nxt = {9'h000, addr_hi_r};
        default: sfr_rdata_nxt = 16'h0000;
      endcase
    end
    if (warm) begin
      // address registers deliberately untouched so software can retry
      go_nxt = 1'b0;
      permit_nxt = 1'b0;
      op_nxt = nvm_seq_pkg::OP_RESET;
      cnt_nxt = '0;
      abort_nxt = abort_r || go_r;
      done_nxt = done_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      go_r <= nvm_seq_pkg::CTRL_RESET[nvm_seq_pkg::GO_BIT];
      permit_r <= nvm_seq_pkg::CTRL_RESET[nvm_seq_pkg::PERMIT_BIT];
      abort_r <= nvm_seq_pkg::CTRL_RESET[nvm_seq_pkg::ABORT_BIT];
      done_r <= 1'b0;
      op_r <= nvm_seq_pkg::OP_RESET;
      act_op_r <= nvm_seq_pkg::OP_RESET;
      cnt_r <= '0;
      addr_lo_r <= 16'h0000;
      addr_hi_r <= 7'h00;
      tgt_r <= 23'h000000;
      sfr_rdata_r <= 16'h0000;
    end else begin
      go_r <= go_nxt;
      permit_r <= permit_nxt;
      abort_r <= abort_nxt;
      done_r <= done_nxt;
      op_r <= op_nxt;
      act_op_r <= act_op_nxt;
      cnt_r <= cnt_nxt;
      addr_lo_r <= addr_lo_nxt;
      addr_hi_r <= addr_hi_nxt;
      tgt_r <= tgt_nxt;
      sfr_rdata_r <= sfr_rdata_nxt;
    end
  end

  // storage arrays carry no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (tbl.wr_low && tbl_ee) begin
      ee_latch[tbl_idx[BW-1:0]] <= tbl.wdata;
    end
    if (tbl.wr_low && tbl_flash) begin
      row_latch[tbl.addr[5:1]][15:0] <= tbl.wdata;
    end
    if (tbl.wr_high && tbl_flash) begin
      row_latch[tbl.addr[5:1]][23:16] <= tbl.wdata[7:0];
    end
    if (op_done && !warm && act_ee) begin
      if (act_multi) begin
        for (int i = 0; i < EE_BLOCK; i++) begin
          ee_mem[{tgt_idx[EW-1:BW], BW'(i)}] <= act_erase ? nvm_seq_pkg::EE_ERASED : ee_latch[i];
        end
      end else begin
        ee_mem[tgt_idx] <= act_erase ? nvm_seq_pkg::EE_ERASED : ee_latch[tgt_idx[BW-1:0]];
      end
    end
    // reads overlapping an operation simply return the old contents
    tbl_rdata_r <= (tbl.rd && tbl_ee) ? ee_mem[tbl_idx] : 16'h0000;
    latch_word_r <= row_latch[latch_sel];
  end

  assign sfr_rdata = sfr_rdata_r;
  assign tbl_rdata = tbl_rdata_r;
  assign latch_word = latch_word_r;
  assign nonvolatile_done_flag = done_r;
  assign cpu_stall = go_r && !act_ee;
  assign flash_erase_cmd = go_r && !act_ee && act_erase;
  assign flash_program_cmd = go_r && !act_ee && !act_erase;
  assign flash_row = tgt_r[22:6];

  sequence s_started;
    $rose(go_r) ##0 $past(armed) && $past(permit_r);
  endsequence

  property p_start_guarded;
    @(posedge clk) disable iff (!reset_n)
    $rose(go_r) |-> s_started;
  endproperty
  a_start_guarded: assert property (p_start_guarded) else $error("go set without keys or permit");

  property p_no_same_write_enable;
    @(posedge clk) disable iff (!reset_n)
    ctrl_wr && !permit_r && !go_r |=> !go_r;
  endproperty
  a_no_same_write_enable: assert property (p_no_same_write_enable) else $error("go and permit set together");

  property p_go_runs;
    @(posedge clk) disable iff (!reset_n || warm)
    s_started |-> go_r [*8];
  endproperty
  a_go_runs: assert property (p_go_runs) else $error("go cleared early");

  property p_go_sticky;
    @(posedge clk) disable iff (!reset_n)
    go_r && !op_done && !warm |=> go_r;
  endproperty
  a_go_sticky: assert property (p_go_sticky) else $error("go dropped before completion");

  property p_duration;
    @(posedge clk) disable iff (!reset_n)
    start && !warm |=> cnt_r == CW'(PROG_CYCLES);
  endproperty
  a_duration: assert property (p_duration) else $error("operation timer not loaded");

  property p_done_flag;
    @(posedge clk) disable iff (!reset_n)
    op_done && !warm |=> !go_r && done_r;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion did not raise done flag");

  property p_done_holds;
    @(posedge clk) disable iff (!reset_n)
    done_r && !done_flag_clear |=> done_r;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("done flag lost without clear");

  property p_abort;
    @(posedge clk) disable iff (!reset_n)
    warm && go_r |=> abort_r && !go_r && $stable(addr_lo_r) && $stable(addr_hi_r);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged or address lost");

  property p_stall;
    @(posedge clk) disable iff (!reset_n)
    start && !warm |=> go_r && cpu_stall == !$past(sfr.wdata[nvm_seq_pkg::OP_EEPROM_BIT]);
  endproperty
  a_stall: assert property (p_stall) else $error("stall does not follow memory type");

  property p_high_byte;
    @(posedge clk) disable iff (!reset_n)
    tbl.wr_high && tbl_flash && !tbl.wr_low |=>
      row_latch[$past(tbl.addr[5:1])][23:16] == $past(tbl.wdata[7:0]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high latch byte wrong");

  property p_addr_capture;
    @(posedge clk) disable iff (!reset_n)
    tbl.wr_low && !warm |=> {addr_hi_r, addr_lo_r} == $past(tbl.addr[22:0]);
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("table address not captured");

  property p_permit_drop_harmless;
    @(posedge clk) disable iff (!reset_n)
    go_r && ctrl_wr && !sfr.wdata[nvm_seq_pkg::PERMIT_BIT] && !op_done && !warm
      |=> go_r && $stable(act_op_r);
  endproperty
  a_permit_drop_harmless: assert property (p_permit_drop_harmless) else $error("permit drop disturbed operation");

  property p_target_latched;
    @(posedge clk) disable iff (!reset_n)
    start && !warm |=> tgt_r[15:0] == $past(addr_lo_r) && tgt_r[22:16] == $past(addr_hi_r);
  endproperty
  a_target_latched: assert property (p_target_latched) else $error("target not taken from address pair");

  property p_high_reads_zero;
    @(posedge clk) disable iff (!reset_n)
    sfr.rd && sfr.addr == nvm_seq_pkg::ADDR_HI_ADDR |=> sfr_rdata[15:7] == 9'h000;
  endproperty
  a_high_reads_zero: assert property (p_high_reads_zero) else $error("unimplemented address bits read back");

endmodule : nvm_program_erase_sequencer

// *** sim/core_model.sv ***
`timescale 1ns/1ps
module core_model (
  // clock
  input wire logic clk,
  // register port
  output nvm_seq_pkg::sfr_req_t sfr,
  input wire logic [15:0] sfr_rdata,
  // table port
  output nvm_seq_pkg::tbl_req_t tbl,
  input wire logic [15:0] tbl_rdata
);
  initial begin
    sfr = '0;
    tbl = '0;
  end

  // released lines show the inverse so a stale copy never passes for a request
  task automatic sfr_acc(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    sfr = '{w, ~w, a, d};
    @(negedge clk);
    q = sfr_rdata;
    sfr = '{1'b0, 1'b0, ~a, ~d};
  endtask : sfr_acc

  // k is {low write, high write, read}
  task automatic tbl_acc(input logic [2:0] k, input logic [23:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    tbl = '{k[2], k[1], k[0], a, d};
    @(negedge clk);
    q = tbl_rdata;
    tbl = '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask : tbl_acc

  // mode 0 keeps the sequence, 1 drops the first key, 2 slips a write between keys, 3 sets permit with go
  task automatic start_op(input logic [6:0] op, input int mode);
    logic [15:0] q;
    sfr_acc(1'b1, nvm_seq_pkg::CTRL_ADDR, {mode == 3 ? 2'b00 : 2'b01, 7'h00, op}, q);
    if (mode != 1)
      sfr_acc(1'b1, nvm_seq_pkg::KEY_ADDR, 16'h0055, q);
    if (mode == 2)
      sfr_acc(1'b1, nvm_seq_pkg::CTRL_ADDR, {9'h080, op}, q);
    sfr_acc(1'b1, nvm_seq_pkg::KEY_ADDR, 16'h00aa, q);
    sfr_acc(1'b1, nvm_seq_pkg::CTRL_ADDR, {9'h180, op}, q);
    repeat (2) @(negedge clk);
  endtask : start_op

  // polls go instead of a fixed wait, since the duration may drift
  task automatic wait_done(output int n);
    logic [15:0] q;
    n = 0;
    q = 16'h8000;
    while (q[15] !== 1'b0 && n < 200) begin
      sfr_acc(1'b0, nvm_seq_pkg::CTRL_ADDR, 16'h0000, q);
      n++;
    end
  endtask : wait_done
endmodule : core_model

// *** sim/tb_nvm_program_erase_sequencer.sv ***
`timescale 1ns/1ps
module tb_nvm_program_erase_sequencer;
  // short programming time keeps the run small
  localparam int PC = 20;
  logic clk, reset_n, ext_rst, wdog_rst, done_clr;
  logic [4:0] latch_sel;
  nvm_seq_pkg::sfr_req_t sfr;
  nvm_seq_pkg::tbl_req_t tbl;
  logic [15:0] sfr_rdata, tbl_rdata, q, d;
  logic done_flag, cpu_stall, erase_cmd, program_cmd;
  logic [16:0] flash_row;
  logic [23:0] latch_word, base;
  logic [23:0] row_exp [32];
  logic [15:0] blk_exp [16];
  int errors, samples_checked, cycles, seed, n, t0, w, j;

  nvm_program_erase_sequencer #(.PROG_CYCLES(PC)) dut_u (
    .clk(clk), .reset_n(reset_n), .external_reset_pin(ext_rst), .watchdog_reset(wdog_rst),
    .sfr(sfr), .sfr_rdata(sfr_rdata), .tbl(tbl), .tbl_rdata(tbl_rdata),
    .done_flag_clear(done_clr), .nonvolatile_done_flag(done_flag), .cpu_stall(cpu_stall),
    .flash_erase_cmd(erase_cmd), .flash_program_cmd(program_cmd), .flash_row(flash_row),
    .latch_sel(latch_sel), .latch_word(latch_word)
  );

  core_model core_u (
    .clk(clk), .sfr(sfr), .sfr_rdata(sfr_rdata), .tbl(tbl), .tbl_rdata(tbl_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  function automatic logic [23:0] ee_addr(input int i);
    return nvm_seq_pkg::EE_BASE + 24'(2 * i);
  endfunction : ee_addr

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic rd(input logic [15:0] a);
    core_u.sfr_acc(1'b0, a, 16'h0000, q);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    core_u.sfr_acc(1'b1, a, v, q);
  endtask : wr

  task automatic ee_rd(input int i);
    core_u.tbl_acc(3'b001, ee_addr(i), 16'h0000, q);
  endtask : ee_rd

  task automatic set_addr(input logic [23:0] a);
    wr(nvm_seq_pkg::ADDR_HI_ADDR, {9'h000, a[22:16]});
    wr(nvm_seq_pkg::ADDR_LO_ADDR, a[15:0]);
  endtask : set_addr

  // one full operation; permit is dropped mid-run on purpose
  task automatic do_op(input logic [6:0] op, input logic [23:0] a);
    set_addr(a);
    core_u.start_op(op, 0);
    t0 = cycles;
    chk("stall", !op[2], cpu_stall);
    chk("erase cmd", op == 7'h41, erase_cmd);
    chk("program cmd", op == 7'h01, program_cmd);
    if (!op[2])
      chk("row", a[22:6], flash_row);
    wr(nvm_seq_pkg::CTRL_ADDR, {9'h000, op});
    rd(nvm_seq_pkg::CTRL_ADDR);
    chk("go held", 24'h008000, q & 16'hc000);
    core_u.wait_done(n);
    chk("duration", 1, cycles - t0 >= PC - 4 && cycles - t0 <= 3 * PC);
    chk("done", 1, done_flag);
    repeat (3) @(negedge clk);
    chk("done sticky", 1, done_flag);
    done_clr = 1'b1;
    @(negedge clk);
    done_clr = 1'b0;
    @(negedge clk);
    chk("done cleared", 0, done_flag);
  endtask : do_op

  initial begin
    seed = 32'h6af90f53;
    reset_n = 1'b0;
    ext_rst = 1'b0;
    wdog_rst = 1'b0;
    done_clr = 1'b0;
    latch_sel = 5'h00;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    rd(nvm_seq_pkg::CTRL_ADDR);
    chk("ctrl reset", 0, q);
    rd(nvm_seq_pkg::KEY_ADDR);
    chk("key read", 0, q);
    rd(16'h0100);
    chk("unmapped", 0, q);
    wr(nvm_seq_pkg::ADDR_HI_ADDR, 16'hffff);
    rd(nvm_seq_pkg::ADDR_HI_ADDR);
    chk("addr hi", 16'h007f, q);
    d = 16'($random(seed));
    wr(nvm_seq_pkg::ADDR_LO_ADDR, d);
    rd(nvm_seq_pkg::ADDR_LO_ADDR);
    chk("addr lo", d, q);
    for (int m = 1; m < 4; m++) begin
      core_u.start_op(7'h44, m);
      rd(nvm_seq_pkg::CTRL_ADDR);
      chk("go refused", 0, q[15]);
    end
    // eeprom: block erase, block program, word erase, word program
    w = {$random(seed)} % 32;
    base = ee_addr(w * 16);
    do_op(7'h45, base + 24'h00000a);
    for (int k = 0; k < 16; k++) begin
      ee_rd(w * 16 + k);
      chk("block erased", 16'hffff, q);
    end
    for (int k = 0; k < 16; k++) begin
      blk_exp[k] = 16'($random(seed));
      core_u.tbl_acc(3'b100, base + 24'(2 * k), blk_exp[k], q);
    end
    rd(nvm_seq_pkg::ADDR_LO_ADDR);
    chk("addr capture", base[15:0] + 16'h001e, q);
    do_op(7'h05, base);
    for (int k = 0; k < 16; k++) begin
      ee_rd(w * 16 + k);
      chk("block prog", blk_exp[k], q);
    end
    j = {$random(seed)} % 16;
    do_op(7'h44, base + 24'(2 * j));
    for (int k = 0; k < 16; k++) begin
      ee_rd(w * 16 + k);
      chk("word erase", k == j ? 16'hffff : blk_exp[k], q);
    end
    d = 16'($random(seed));
    core_u.tbl_acc(3'b100, base + 24'(2 * j), d, q);
    do_op(7'h04, base + 24'(2 * j));
    ee_rd(w * 16 + j);
    chk("word prog", d, q);
    // warm resets mid-run: pin first, then watchdog
    for (int r = 0; r < 2; r++) begin
      set_addr(base);
      core_u.start_op(7'h44, 0);
      if (r == 0)
        ext_rst = 1'b1;
      else
        wdog_rst = 1'b1;
      @(negedge clk);
      ext_rst = 1'b0;
      wdog_rst = 1'b0;
      rd(nvm_seq_pkg::CTRL_ADDR);
      chk("aborted", 16'h2000, q & 16'he000);
      rd(nvm_seq_pkg::ADDR_LO_ADDR);
      chk("addr kept", base[15:0], q);
      wr(nvm_seq_pkg::CTRL_ADDR, 16'h0000);
    end
    // flash row staging; upper byte of the high write must drop
    base = 24'({$random(seed)}) & 24'h00ffc0;
    for (int k = 0; k < 32; k++) begin
      d = 16'($random(seed));
      n = $random(seed);
      row_exp[k] = {n[7:0], d};
      core_u.tbl_acc(3'b100, base + 24'(2 * k), d, q);
      core_u.tbl_acc(3'b010, base + 24'(2 * k), n[15:0], q);
    end
    for (int k = 0; k < 32; k++) begin
      latch_sel = k[4:0];
      @(negedge clk);
      chk("latch word", row_exp[k], latch_word);
    end
    do_op(7'h41, base);
    do_op(7'h01, base);
    end_sim();
  end
endmodule : tb_nvm_program_erase_sequencer
